// [rtl/wipd_regs.vh]
// Purpose: constants shared by the window image parameter decoder
// Assumes: byte offsets count from the start of the window descriptor
// Notes:   register offsets are Avalon-MM byte addresses
`ifndef WIPD_REGS_VH
`define WIPD_REGS_VH

// ==========================================================
// Register map
`define WIPD_REG_STATUS      5'h00
`define WIPD_REG_CLEAR       5'h04
`define WIPD_REG_ENABLE      5'h08
`define WIPD_REG_CONTROL     5'h0C
`define WIPD_REG_RESULT      5'h10
`define WIPD_REG_WIDTH       5'h14
`define WIPD_REG_LENGTH      5'h18
`define WIPD_REG_ORIGIN      5'h1C
`define WIPD_STATUS_RST      3'h0
`define WIPD_ENABLE_RST      3'h0
`define WIPD_CONTROL_RST     2'h0
`define WIPD_EV_DONE         0
`define WIPD_EV_ILLEGAL      1
`define WIPD_EV_NO_EXT       2
`define WIPD_CTL_OPTION      0
`define WIPD_CTL_FEEDER      1

// ==========================================================
// Window descriptor byte positions
`define WIPD_B_ULX_MSB       8'h06
`define WIPD_B_ULX_LSB       8'h09
`define WIPD_B_PIXFMT        8'h19
`define WIPD_B_EXT_FIRST     8'h28
`define WIPD_B_EXT_LAST      8'h3F
`define WIPD_B_SIMP_PARAM    8'h2E
`define WIPD_B_MODE_A        8'h2F
`define WIPD_B_MODE_B        8'h30
`define WIPD_B_FOLLOWER      8'h32
`define WIPD_B_BARCODE       8'h33
`define WIPD_B_SUBWIN        8'h34
`define WIPD_B_PAPER         8'h35
`define WIPD_B_PW_MSB        8'h36
`define WIPD_B_PW_LSB        8'h39
`define WIPD_B_PL_MSB        8'h3A
`define WIPD_B_PL_LSB        8'h3D
`define WIPD_B_SELECT        8'h3E
`define WIPD_EXT_LEN         5'h18
`define WIPD_EXT_ID          8'h00

// ==========================================================
// Field codes
`define WIPD_FOL_DEFAULT     8'h00
`define WIPD_FOL_ON          8'h80
`define WIPD_FOL_OFF         8'hC0
`define WIPD_PIX_ON          8'h00
`define WIPD_SEL_DEFAULT     8'h00
`define WIPD_SEL_FULL        8'h40
`define WIPD_SEL_SIMP        8'h80
`define WIPD_PAPER_OFF       8'h00
`define WIPD_PAPER_STD       2'h2
`define WIPD_PAPER_CUSTOM    2'h3
`define WIPD_SZ_A3           4'h3
`define WIPD_SZ_A4           4'h4
`define WIPD_SZ_A5           4'h5
`define WIPD_SZ_LEDGER       4'h6
`define WIPD_SZ_LETTER       4'h7
`define WIPD_SZ_B4           4'hC
`define WIPD_SZ_B5           4'hD
`define WIPD_SZ_LEGAL        4'hF

// ==========================================================
// Sheet sizes in 1/1200 inch, width then length
`define WIPD_A3_W            32'h000036CF
`define WIPD_A3_L            32'h00004D83
`define WIPD_A4_W            32'h000026C1
`define WIPD_A4_L            32'h000036CF
`define WIPD_A5_W            32'h00001B50
`define WIPD_A5_L            32'h000026C1
`define WIPD_LEDGER_W        32'h00003390
`define WIPD_LEDGER_L        32'h00004FB0
`define WIPD_LETTER_W        32'h000027D8
`define WIPD_LETTER_L        32'h00003390
`define WIPD_B4_W            32'h00002F6E
`define WIPD_B4_L            32'h0000432D
`define WIPD_B5_W            32'h00002196
`define WIPD_B5_L            32'h00002F6E
`define WIPD_LEGAL_W         32'h000027D8
`define WIPD_LEGAL_L         32'h000041A0

`endif

// [rtl/wipd_paper_lookup.v]
// Purpose: maps a standard sheet code to its width and length
// Assumes: sizes in 1/1200 inch
// Notes:   larger sheets exist only on the large model
`include "wipd_regs.vh"

module wipd_paper_lookup #(
  parameter LARGE_MODEL = 1
) (
  input  wire [3:0]  size_code,
  output reg         size_known,
  output reg  [31:0] size_width,
  output reg  [31:0] size_length
);

  always @* begin
    size_known  = 1'b1;
    size_width  = 32'h00000000;
    size_length = 32'h00000000;
    case (size_code)
      `WIPD_SZ_A4: begin
        size_width  = `WIPD_A4_W;
        size_length = `WIPD_A4_L;
      end
      `WIPD_SZ_A5: begin
        size_width  = `WIPD_A5_W;
        size_length = `WIPD_A5_L;
      end
      `WIPD_SZ_LETTER: begin
        size_width  = `WIPD_LETTER_W;
        size_length = `WIPD_LETTER_L;
      end
      `WIPD_SZ_B5: begin
        size_width  = `WIPD_B5_W;
        size_length = `WIPD_B5_L;
      end
      `WIPD_SZ_LEGAL: begin
        size_width  = `WIPD_LEGAL_W;
        size_length = `WIPD_LEGAL_L;
      end
      `WIPD_SZ_A3: begin
        size_known  = (LARGE_MODEL != 0);
        size_width  = `WIPD_A3_W;
        size_length = `WIPD_A3_L;
      end
      `WIPD_SZ_LEDGER: begin
        size_known  = (LARGE_MODEL != 0);
        size_width  = `WIPD_LEDGER_W;
        size_length = `WIPD_LEDGER_L;
      end
      `WIPD_SZ_B4: begin
        size_known  = (LARGE_MODEL != 0);
        size_width  = `WIPD_B4_W;
        size_length = `WIPD_B4_L;
      end
      default: begin
        size_known  = 1'b0;
      end
    endcase
  end

endmodule

// [rtl/wipd_decoder.v]
// Purpose: decodes the later image parameter bytes of a set-window descriptor
// Assumes: descriptor bytes arrive on the controller clock with their offset
// Notes:   settings change only when a whole descriptor decodes cleanly
//
// Added by the designer: the Avalon-MM register port and the placing of the registers.
`include "wipd_regs.vh"

// Functional notes
// - Extension is recognised by id 00h and 24 bytes; fields at bytes 46 to 62.
// - Mode byte B: noise removal, matrix sizes, equal-to-threshold colour.
// - Follower 80h on, C0h off, other nonzero values reserved.
// - Follower 00h: on for pixel format 00h, off for 01h.
// - Paper size 00h disables paper size handling.
// - Paper 10b: low nibble picks standard sheet; three sizes only on large model.
// - Paper 11b: width from four-byte field in 1/1200 inch.
// - Custom paper: length from four-byte field in 1/1200 inch.
// - Feeder used with no paper size: A3 large model, A4 small.
// - Window origin measured from the feeder centre line using paper width.
// - Selection 00h/80h simplified, 40h full circuit, rest reserved; option needed; 00h accepted without it.
// - Simplified circuit takes its variance from the simplified parameter byte.
// - Full circuit is configured from both mode bytes.
module wipd_decoder #(
  parameter        LARGE_MODEL   = 1,
  parameter [31:0] FEEDER_CENTRE = 32'h00001B00
) (
  input  wire        clock,
  input  wire        resetn,
  input  wire [4:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire        wd_valid,
  input  wire [7:0]  wd_offset,
  input  wire [7:0]  wd_byte,
  input  wire        wd_end,
  output reg         decode_done,
  output reg         illegal_request,
  output reg         noise_removal_en,
  output reg         matrix_5x5_en,
  output reg         matrix_4x4_en,
  output reg         matrix_3x3_en,
  output reg         matrix_2x2_en,
  output reg         equal_is_black,
  output reg         follower_en,
  output reg         paper_handling_en,
  output reg         paper_landscape,
  output reg  [31:0] paper_width,
  output reg  [31:0] paper_length,
  output reg         use_full_circuit,
  output reg  [7:0]  simp_variance,
  output reg  [7:0]  full_mode_a,
  output reg  [7:0]  full_mode_b,
  output reg  [31:0] window_origin_x,
  output reg         irq
);

  // ==========================================================
  // Descriptor capture
  reg [7:0]  ext_id_q;
  reg [4:0]  ext_cnt_q;
  reg [7:0]  pixfmt_q;
  reg [31:0] ulx_q;
  reg [7:0]  simp_q;
  reg [7:0]  mode_a_q;
  reg [7:0]  mode_b_q;
  reg [7:0]  fol_q;
  reg [7:0]  bar_q;
  reg [7:0]  sub_q;
  reg [7:0]  paper_q;
  reg [31:0] pw_q;
  reg [31:0] pl_q;
  reg [7:0]  sel_q;

  wire in_ext = (wd_offset >= `WIPD_B_EXT_FIRST) && (wd_offset <= `WIPD_B_EXT_LAST);
  wire in_ulx = (wd_offset >= `WIPD_B_ULX_MSB) && (wd_offset <= `WIPD_B_ULX_LSB);
  wire in_pw  = (wd_offset >= `WIPD_B_PW_MSB) && (wd_offset <= `WIPD_B_PW_LSB);
  wire in_pl  = (wd_offset >= `WIPD_B_PL_MSB) && (wd_offset <= `WIPD_B_PL_LSB);

  always @(posedge clock) begin
    if (!resetn || wd_end) begin
      // Absent id until byte 40 arrives, so a short descriptor is no extension
      ext_id_q  <= 8'hFF;
      ext_cnt_q <= 5'h00;
      pixfmt_q  <= 8'h00;
      ulx_q     <= 32'h00000000;
      simp_q    <= 8'h00;
      mode_a_q  <= 8'h00;
      mode_b_q  <= 8'h00;
      fol_q     <= 8'h00;
      bar_q     <= 8'h00;
      sub_q     <= 8'h00;
      paper_q   <= 8'h00;
      pw_q      <= 32'h00000000;
      pl_q      <= 32'h00000000;
      sel_q     <= 8'h00;
    end else if (wd_valid) begin
      if (in_ext && ext_cnt_q != `WIPD_EXT_LEN)
        ext_cnt_q <= ext_cnt_q + 5'h01;
      if (in_ulx)
        ulx_q <= {ulx_q[23:0], wd_byte};
      if (in_pw)
        pw_q <= {pw_q[23:0], wd_byte};
      if (in_pl)
        pl_q <= {pl_q[23:0], wd_byte};
      case (wd_offset)
        `WIPD_B_EXT_FIRST:  ext_id_q <= wd_byte;
        `WIPD_B_PIXFMT:     pixfmt_q <= wd_byte;
        `WIPD_B_SIMP_PARAM: simp_q   <= wd_byte;
        `WIPD_B_MODE_A:     mode_a_q <= wd_byte;
        `WIPD_B_MODE_B:     mode_b_q <= wd_byte;
        `WIPD_B_FOLLOWER:   fol_q    <= wd_byte;
        `WIPD_B_BARCODE:    bar_q    <= wd_byte;
        `WIPD_B_SUBWIN:     sub_q    <= wd_byte;
        `WIPD_B_PAPER:      paper_q  <= wd_byte;
        `WIPD_B_SELECT:     sel_q    <= wd_byte;
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Field decode
  reg  [1:0] ctl_q;
  wire       opt_present = ctl_q[`WIPD_CTL_OPTION];
  wire       feeder_used = ctl_q[`WIPD_CTL_FEEDER];
  wire       ext_ok = (ext_id_q == `WIPD_EXT_ID) && (ext_cnt_q == `WIPD_EXT_LEN);

  wire        std_known;
  wire [31:0] std_width;
  wire [31:0] std_length;
  wire        dflt_known;
  wire [31:0] dflt_width;
  wire [31:0] dflt_length;

  wipd_paper_lookup #(.LARGE_MODEL(LARGE_MODEL)) u_std (
    .size_code   (paper_q[3:0]),
    .size_known  (std_known),
    .size_width  (std_width),
    .size_length (std_length)
  );

  // Feeder default sheet depends on the model
  wipd_paper_lookup #(.LARGE_MODEL(LARGE_MODEL)) u_dflt (
    .size_code   ((LARGE_MODEL != 0) ? `WIPD_SZ_A3 : `WIPD_SZ_A4),
    .size_known  (dflt_known),
    .size_width  (dflt_width),
    .size_length (dflt_length)
  );

  reg [7:0]  mode_b_d;
  reg        fol_d;
  reg        paper_en_d;
  reg [31:0] pw_d;
  reg [31:0] pl_d;
  reg        full_d;
  reg        bad_d;

  always @* begin
    bad_d      = 1'b0;
    mode_b_d   = ext_ok ? mode_b_q : 8'h00;
    fol_d      = (pixfmt_q == `WIPD_PIX_ON);
    paper_en_d = 1'b0;
    pw_d       = 32'h00000000;
    pl_d       = 32'h00000000;
    full_d     = 1'b0;
    if (ext_ok) begin
      case (fol_q)
        `WIPD_FOL_DEFAULT: fol_d = (pixfmt_q == `WIPD_PIX_ON);
        `WIPD_FOL_ON:      fol_d = 1'b1;
        `WIPD_FOL_OFF:     fol_d = 1'b0;
        default:           bad_d = 1'b1;
      endcase
      if (bar_q != 8'h00 || sub_q != 8'h00)
        bad_d = 1'b1;
      if (paper_q != `WIPD_PAPER_OFF) begin
        paper_en_d = 1'b1;
        if (paper_q[5])
          bad_d = 1'b1;
        if (paper_q[7:6] == `WIPD_PAPER_STD) begin
          pw_d = std_width;
          pl_d = std_length;
          if (!std_known)
            bad_d = 1'b1;
        end else if (paper_q[7:6] == `WIPD_PAPER_CUSTOM) begin
          pw_d = pw_q;
          pl_d = pl_q;
        end else begin
          bad_d = 1'b1;
        end
      end
      case (sel_q)
        `WIPD_SEL_DEFAULT: full_d = 1'b0;
        `WIPD_SEL_SIMP: begin
          full_d = 1'b0;
          if (!opt_present)
            bad_d = 1'b1;
        end
        `WIPD_SEL_FULL: begin
          full_d = 1'b1;
          if (!opt_present)
            bad_d = 1'b1;
        end
        default: bad_d = 1'b1;
      endcase
    end
    if (!paper_en_d && feeder_used && dflt_known) begin
      pw_d = dflt_width;
      pl_d = dflt_length;
    end
  end

  // Window left edge from the feeder centre; wraps below zero when half the paper width exceeds FEEDER_CENTRE plus ulx_q
  wire [31:0] origin_d = FEEDER_CENTRE - {1'b0, pw_d[31:1]} + ulx_q;

  // ==========================================================
  // Applied settings
  always @(posedge clock) begin
    if (!resetn) begin
      decode_done       <= 1'b0;
      illegal_request   <= 1'b0;
      noise_removal_en  <= 1'b1;
      matrix_5x5_en     <= 1'b0;
      matrix_4x4_en     <= 1'b1;
      matrix_3x3_en     <= 1'b1;
      matrix_2x2_en     <= 1'b1;
      equal_is_black    <= 1'b0;
      follower_en       <= 1'b1;
      paper_handling_en <= 1'b0;
      paper_landscape   <= 1'b0;
      paper_width       <= 32'h00000000;
      paper_length      <= 32'h00000000;
      use_full_circuit  <= 1'b0;
      simp_variance     <= 8'h00;
      full_mode_a       <= 8'h00;
      full_mode_b       <= 8'h00;
      window_origin_x   <= 32'h00000000;
    end else begin
      decode_done     <= wd_end;
      illegal_request <= wd_end && bad_d;
      if (wd_end && !bad_d) begin
        noise_removal_en  <= !mode_b_d[5];
        matrix_5x5_en     <= mode_b_d[4];
        matrix_4x4_en     <= !mode_b_d[3];
        matrix_3x3_en     <= !mode_b_d[2];
        matrix_2x2_en     <= !mode_b_d[1];
        equal_is_black    <= mode_b_d[0];
        follower_en       <= fol_d;
        paper_handling_en <= paper_en_d;
        paper_landscape   <= paper_en_d && paper_q[4];
        paper_width       <= pw_d;
        paper_length      <= pl_d;
        use_full_circuit  <= full_d;
        simp_variance     <= (ext_ok && !full_d) ? simp_q : 8'h00;
        full_mode_a       <= (ext_ok && full_d) ? mode_a_q : 8'h00;
        full_mode_b       <= (ext_ok && full_d) ? mode_b_q : 8'h00;
        window_origin_x   <= origin_d;
      end
    end
  end

  // ==========================================================
  // Avalon-MM slave, one wait cycle per access
  reg  [2:0] sts_q;
  reg  [2:0] en_q;
  wire       req     = avs_read || avs_write;
  wire       wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire [2:0] ev      = {wd_end && !ext_ok, wd_end && bad_d, wd_end};
  reg  [2:0] clr;
  reg  [31:0] rd_d;

  always @* begin
    clr = 3'h0;
    if (wr_done && avs_address == `WIPD_REG_CLEAR)
      clr = avs_writedata[2:0];
  end

  always @* begin
    case (avs_address)
      `WIPD_REG_STATUS:  rd_d = {29'h0, sts_q};
      `WIPD_REG_ENABLE:  rd_d = {29'h0, en_q};
      `WIPD_REG_CONTROL: rd_d = {30'h0, ctl_q};
      `WIPD_REG_RESULT:  rd_d = {8'h00, simp_variance, 4'h0, use_full_circuit,
                                 paper_landscape, paper_handling_en, follower_en,
                                 2'h0, equal_is_black, matrix_2x2_en, matrix_3x3_en,
                                 matrix_4x4_en, matrix_5x5_en, noise_removal_en};
      `WIPD_REG_WIDTH:   rd_d = paper_width;
      `WIPD_REG_LENGTH:  rd_d = paper_length;
      `WIPD_REG_ORIGIN:  rd_d = window_origin_x;
      default:           rd_d = 32'h00000000;
    endcase
  end

  always @(posedge clock) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
      sts_q           <= `WIPD_STATUS_RST;
      en_q            <= `WIPD_ENABLE_RST;
      ctl_q           <= `WIPD_CONTROL_RST;
      irq             <= 1'b0;
    end else begin
      avs_waitrequest <= !(req && avs_waitrequest);
      if (avs_read && avs_waitrequest)
        avs_readdata <= rd_d;
      // A new event wins over a clear in the same cycle
      sts_q <= (sts_q & ~clr) | ev;
      if (wr_done && avs_address == `WIPD_REG_ENABLE)
        en_q <= avs_writedata[2:0];
      if (wr_done && avs_address == `WIPD_REG_CONTROL)
        ctl_q <= avs_writedata[1:0];
      irq <= |(sts_q & en_q);
    end
  end

endmodule

// [verification/wipd_decoder_sva.sv]
// Purpose: port checks for the window parameter decoder
// Assumes: one clock, synchronous active-low reset
// Notes:   mode byte B is captured from the stream to judge the decoded flags
module wipd_decoder_sva (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic        wd_valid,
  input wire logic [7:0]  wd_offset,
  input wire logic [7:0]  wd_byte,
  input wire logic        wd_end,
  input wire logic        decode_done,
  input wire logic        illegal_request,
  input wire logic        noise_removal_en,
  input wire logic        matrix_5x5_en,
  input wire logic        matrix_4x4_en,
  input wire logic        equal_is_black,
  input wire logic        follower_en,
  input wire logic [31:0] paper_width,
  input wire logic        use_full_circuit,
  input wire logic [7:0]  full_mode_b
);
  logic [7:0] mb_q;

  // ==========================================================
  // Capture
  // Cleared at each completion so a descriptor without the byte reads as 00h
  always @(posedge clock) begin
    if (!resetn || decode_done) begin
      mb_q <= 8'h00;
    end else if (wd_valid && wd_offset == 8'h30) begin
      mb_q <= wd_byte;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_end;
    wd_end;
  endsequence
  sequence s_done;
    ##1 decode_done;
  endsequence

  a_done_follows: assert property (s_end |-> s_done)
    else $error("no completion after descriptor end");
  a_done_cause: assert property (decode_done |-> $past(wd_end))
    else $error("completion without descriptor end");
  a_illegal_pulse: assert property (illegal_request |-> decode_done)
    else $error("illegal flag outside completion");
  a_illegal_hold: assert property (illegal_request |-> $stable(paper_width)
    && $stable(follower_en) && $stable(use_full_circuit))
    else $error("settings changed on illegal descriptor");
  a_settings_hold: assert property (!decode_done |-> $stable(follower_en)
    && $stable(use_full_circuit))
    else $error("settings changed between completions");
  a_mode_map: assert property (decode_done && !illegal_request |->
    (noise_removal_en || mb_q[5]) && (!matrix_5x5_en || mb_q[4])
    && (matrix_4x4_en || mb_q[3]) && (!equal_is_black || mb_q[0]))
    else $error("mode byte flags wrong");
  a_full_mode: assert property (decode_done && !illegal_request && use_full_circuit |->
    full_mode_b == mb_q)
    else $error("full circuit mode byte wrong");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus access not answered");
  a_bus_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
endmodule

// [verification/wipd_host_model.sv]
// Purpose: host initiator model streaming one window descriptor per request
// Assumes: bytes leave in rising offset order, one strobe per byte
// Notes:   idle byte lines keep changing so stale data never looks valid
module wipd_host_model (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic             go,
  input  wire logic             slow,
  input  wire logic [63:0][7:0] desc,
  output logic                  wd_valid = 1'b0,
  output logic [7:0]            wd_offset = 8'h00,
  output logic [7:0]            wd_byte = 8'h00,
  output logic                  wd_end = 1'b0
);
  int   idx = 0;
  int   gap = 0;
  logic busy = 1'b0;

  // ==========================================================
  // Byte sequencer
  always @(posedge clock) begin
    wd_valid <= 1'b0;
    wd_end <= 1'b0;
    wd_offset <= ~wd_offset;
    wd_byte <= wd_byte + 8'h5B;
    if (!resetn) begin
      busy <= 1'b0;
    end else if (go && !busy) begin
      busy <= 1'b1;
      idx <= 0;
      gap <= 0;
    end else if (busy && gap > 0) begin
      gap <= gap - 1;
    end else if (busy && idx < 64) begin
      wd_valid <= 1'b1;
      wd_offset <= 8'(idx);
      wd_byte <= desc[idx];
      idx <= idx + 1;
      gap <= slow ? idx % 3 : 0;
    end else if (busy) begin
      wd_end <= 1'b1;
      busy <= 1'b0;
    end
  end
endmodule

// [verification/tb_top.sv]
// Purpose: self-checking bench for the window parameter decoder
// Assumes: host model streams whole descriptors; bench owns the register bus
// Notes:   a reference model predicts every decode from the field rules
`include "wipd_regs.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected at %0t got %h want %h", $time, g, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, resetn = 0, avs_read = 0, avs_write = 0, go = 0, slow = 0, opt, feed;
  logic [4:0]       avs_address = 0;
  logic [3:0]       avs_byteenable = 4'hF;
  logic [31:0]      avs_writedata = 0, rd, v, e_w = 0, e_l = 0, e_org = 0;
  logic [31:0]      e_res = 32'h0000011D, e_msk = 32'h00FF0F3F;
  logic [63:0][7:0] d = '0;
  logic [7:0]       e_fa, e_fb, en;
  logic             e_ill, e_nox, e_ck = 1'b1;
  int               err_total = 0, samples_checked = 0, seed = 32'hae82, k, i;
  wire [31:0] avs_readdata, paper_width, paper_length, window_origin_x;
  wire [7:0]  wd_offset, wd_byte, simp_variance, full_mode_a, full_mode_b;
  wire avs_waitrequest, wd_valid, wd_end, decode_done, illegal_request, noise_removal_en;
  wire matrix_5x5_en, matrix_4x4_en, matrix_3x3_en, matrix_2x2_en, equal_is_black, irq;
  wire follower_en, paper_handling_en, paper_landscape, use_full_circuit;
  wire [31:0] got = {8'h00, simp_variance, 4'h0, use_full_circuit, paper_landscape,
    paper_handling_en, follower_en, 2'b00, equal_is_black, matrix_2x2_en, matrix_3x3_en,
    matrix_4x4_en, matrix_5x5_en, noise_removal_en};
  logic [7:0] fol_t [4] = '{8'h00, 8'h80, 8'hC0, 8'h41};
  logic [7:0] sel_t [8] = '{8'h00, 8'h40, 8'h80, 8'hC0, 8'h40, 8'h80, 8'h00, 8'h17};

  wipd_decoder u_wipd_decoder (.clock, .resetn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .wd_valid,
    .wd_offset, .wd_byte, .wd_end, .decode_done, .illegal_request, .noise_removal_en,
    .matrix_5x5_en, .matrix_4x4_en, .matrix_3x3_en, .matrix_2x2_en, .equal_is_black,
    .follower_en, .paper_handling_en, .paper_landscape, .paper_width, .paper_length,
    .use_full_circuit, .simp_variance, .full_mode_a, .full_mode_b, .window_origin_x, .irq);
  wipd_host_model u_wipd_host_model (.clock, .resetn, .go, .slow, .desc(d), .wd_valid,
    .wd_offset, .wd_byte, .wd_end);

  initial begin
    forever #2.5 clock = ~clock;
  end

  // ==========================================================
  // Bus, reference model and closing
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] x);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= x;
    avs_write <= wr;
    avs_read <= !wr;
    do begin @(posedge clock); n++; end while (avs_waitrequest !== 1'b0 && n < 40);
    rd = avs_readdata;
    if (n >= 40) err_total++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask

  task automatic predict;
    logic [7:0] mb, fl, pp, sl;
    logic [31:0] r, m, w, l;
    logic il, ex, ck;
    ex = d[40] == 8'h00;
    mb = ex ? d[48] : 8'h00;
    fl = ex ? d[50] : 8'h00;
    pp = ex ? d[53] : 8'h00;
    sl = ex ? d[62] : 8'h00;
    r = {8'h00, d[46], 5'h00, pp[4], pp != 8'h00, 3'h0, mb[0], ~mb[1], ~mb[2], ~mb[3],
         mb[4], ~mb[5]};
    m = (!ex || !opt || sl == 8'h40) ? 32'h00000F3F : 32'h00FF0F3F;
    il = ex && (d[51] != 8'h00 || d[52] != 8'h00);
    if (fl == 8'h00) r[8] = d[25] == 8'h00;
    else if (fl == 8'h80 || fl == 8'hC0) r[8] = ~fl[6];
    else il = 1'b1;
    ck = 1'b1;
    {w, l} = {`WIPD_A3_W, `WIPD_A3_L};
    if (pp == 8'h00) ck = feed;
    else if (pp[5] || !pp[7]) il = 1'b1;
    else if (pp[6]) {w, l} = {d[54], d[55], d[56], d[57], d[58], d[59], d[60], d[61]};
    else case (pp[3:0])
      4'h3: {w, l} = {`WIPD_A3_W, `WIPD_A3_L};
      4'h4: {w, l} = {`WIPD_A4_W, `WIPD_A4_L};
      4'h5: {w, l} = {`WIPD_A5_W, `WIPD_A5_L};
      4'h6: {w, l} = {`WIPD_LEDGER_W, `WIPD_LEDGER_L};
      4'h7: {w, l} = {`WIPD_LETTER_W, `WIPD_LETTER_L};
      4'hC: {w, l} = {`WIPD_B4_W, `WIPD_B4_L};
      4'hD: {w, l} = {`WIPD_B5_W, `WIPD_B5_L};
      4'hF: {w, l} = {`WIPD_LEGAL_W, `WIPD_LEGAL_L};
      default: il = 1'b1;
    endcase
    if (sl == 8'h40 && opt) r[11] = 1'b1;
    else if (sl != 8'h00 && !(sl == 8'h80 && opt)) il = 1'b1;
    e_ill = il;
    e_nox = !ex;
    if (!il) begin
      {e_res, e_msk, e_w, e_l, e_ck, e_fa, e_fb} = {r, m, w, l, ck, d[47], mb};
      e_org = 32'h00001B00 - (w >> 1) + {d[6], d[7], d[8], d[9]};
    end
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clock);
    err_total++;
    print_verdict;
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    bus(0, `WIPD_REG_RESULT, 0);
    `CHK(rd, 32'h0000011D)
    bus(0, `WIPD_REG_STATUS, 0);
    `CHK(rd, 32'h0)
    for (k = 0; k < 64; k++) begin
      v = $random(seed);
      {feed, opt, slow, en} = {v[12:11], k[0], 5'h00, v[15:13]};
      bus(1, `WIPD_REG_CONTROL, {30'h0, feed, opt});
      bus(1, `WIPD_REG_ENABLE, {24'h0, en});
      for (i = 0; i < 64; i++) d[i] = 8'($random(seed));
      {d[6], d[7], d[8]} = 24'h0;
      d[25] = {7'h0, v[9]};
      d[40] = (k % 13 == 7) ? 8'h01 : 8'h00;
      d[50] = fol_t[v[1:0]];
      {d[51], d[52]} = (v[8:6] == 3'h0) ? {8'h00, v[23:16]} : 16'h0;
      d[53] = (k % 4 == 0) ? 8'h00 : (k % 4 == 1) ? {4'h8, k[5:2]} :
              (k % 4 == 2) ? {3'h6, v[10], 4'h0} : v[31:24];
      {d[54], d[55]} = 16'h0;
      d[62] = sel_t[v[4:2]];
      predict;
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      i = 0;
      do begin @(posedge clock); i++; end while (decode_done !== 1'b1 && i < 400);
      if (i >= 400) err_total++;
      `CHK(illegal_request, e_ill)
      `CHK(got & e_msk, e_res & e_msk)
      if (e_ck) `CHK({paper_width, paper_length, window_origin_x}, {e_w, e_l, e_org})
      if (e_res[11]) `CHK({full_mode_a, full_mode_b}, {e_fa, e_fb})
      bus(0, `WIPD_REG_STATUS, 0);
      `CHK(rd[2:0], {e_nox, e_ill, 1'b1})
      `CHK(irq, |({e_nox, e_ill, 1'b1} & en[2:0]))
      bus(0, `WIPD_REG_RESULT, 0);
      `CHK(rd & e_msk, e_res & e_msk)
      if (e_ck) bus(0, `WIPD_REG_WIDTH, 0);
      if (e_ck) `CHK(rd, e_w)
      bus(1, `WIPD_REG_CLEAR, 32'h7);
      @(posedge clock);
      `CHK(irq, 1'b0)
      $display("test %0d done", k);
    end
    avs_byteenable <= 4'h0;
    bus(1, `WIPD_REG_ENABLE, 32'h5);
    avs_byteenable <= 4'hF;
    bus(0, `WIPD_REG_ENABLE, 0);
    `CHK(rd, {24'h0, en})
    bus(0, 5'h02, 0);
    `CHK(rd, 32'h0)
    print_verdict;
  end
endmodule

bind wipd_decoder wipd_decoder_sva u_wipd_decoder_sva (.clock, .resetn, .avs_read,
  .avs_write, .avs_waitrequest, .wd_valid, .wd_offset, .wd_byte, .wd_end, .decode_done,
  .illegal_request, .noise_removal_en, .matrix_5x5_en, .matrix_4x4_en, .equal_is_black,
  .follower_en, .paper_width, .use_full_circuit, .full_mode_b);
